// [core/rss_pkg.sv]
package rss_pkg;
    // Synchroniser depth for the reset input
    localparam int SYNC_STAGES = 2;
    // Cycles after reset release at which the coprocessor wait pin is sampled again
    localparam int COPROC_DELAY_CLKS = 4;
    // Cycles the bus controls are driven inactive before they float
    localparam int INACTIVE_DRIVE_CLKS = 1;
    // Strap pin positions in the strap bus
    localparam int STRAP_W = 7;
    localparam int STRAP_READ_QUEUE = 0;
    localparam int STRAP_UPPER_SEL = 1;
    localparam int STRAP_LOWER_SEL = 2;
    localparam int STRAP_MID0 = 3;
    localparam int STRAP_MID1 = 4;
    localparam int STRAP_LOCK = 5;
    localparam int STRAP_COPROC_WAIT = 6;
    localparam logic [STRAP_W-1:0] STRAP_PULLUP = 7'h7F;
    // AHB-Lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [1:0] HSIZE_WORD = 2'h2;
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam int MODE_FLOAT_BIT = 0;
    localparam int MODE_QUEUE_BIT = 1;
    localparam int MODE_COPROC_BIT = 2;
    localparam int STAT_RESET_BIT = 0;
    localparam int STAT_FLOAT_BIT = 1;
    localparam int STAT_LOCKERR_BIT = 2;
    localparam int CTRL_HOLD_BIT = 0;
    typedef enum logic [2:0] {
        ST_RESET,
        ST_INACTIVE,
        ST_COPROC_WAIT,
        ST_RUN
    } rss_state_e;
endpackage

// [core/rss_sync_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface rss_sync_if;
    logic raw_n;
    logic synced_n;
    modport producer (input raw_n, output synced_n);
    modport consumer (output raw_n, input synced_n);
endinterface
`default_nettype wire

// [core/rss_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module rss_sync #(
    parameter int STAGES = rss_pkg::SYNC_STAGES
) (
    // Clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // Reset input to be synchronised
    rss_sync_if.producer sif
);
    logic [STAGES-1:0] sync_r;

    // Power-on reset clears at once; the reset input asserts and releases only on clock edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_r <= '0;
        end else begin
            sync_r <= {sync_r[STAGES-2:0], sif.raw_n};
        end
    end

    assign sif.synced_n = sync_r[STAGES-1];
endmodule // rss_sync
`default_nettype wire

// [core/rss_top.sv]
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rss_top #(
    parameter int COPROC_DELAY = rss_pkg::COPROC_DELAY_CLKS,
    parameter int INACTIVE_CLKS = rss_pkg::INACTIVE_DRIVE_CLKS
) (
    // Clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // Board reset and strap pins
    input wire logic reset_in_n,
    input wire logic [rss_pkg::STRAP_W-1:0] strap_in,
    output logic [rss_pkg::STRAP_W-1:0] strap_out,
    output logic [rss_pkg::STRAP_W-1:0] strap_oe_n,
    output logic [rss_pkg::STRAP_W-1:0] strap_pullup,
    // Bus control pins
    output logic bus_ctrl_oe_n,
    output logic core_reset_n,
    // Mode flags
    output logic emulation_float_mode,
    output logic queue_report_strap,
    output logic coproc_mode,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    rss_sync_if sif();
    rss_pkg::rss_state_e state_r, state_nxt;
    logic [rss_pkg::STRAP_W-1:0] strap_s1_r, strap_s2_r;
    logic [7:0] cnt_r;
    logic float_r, queue_r, coproc_r, lockerr_r, hold_r;
    logic ctrl_oe_n_r, core_rst_n_r;
    logic [rss_pkg::STRAP_W-1:0] pin_oe_n_r, pin_pu_r;
    logic dp_valid_r, dp_write_r;
    logic [11:0] dp_addr_r;
    logic [31:0] hrdata_r;

    assign sif.raw_n = reset_in_n;
    rss_sync #(.STAGES(rss_pkg::SYNC_STAGES)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .sif(sif)
    );

    // Straps are pins: two flops before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_s1_r <= rss_pkg::STRAP_PULLUP;
            strap_s2_r <= rss_pkg::STRAP_PULLUP;
        end else begin
            strap_s1_r <= strap_in;
            strap_s2_r <= strap_s1_r;
        end
    end

    wire in_reset = !sif.synced_n || hold_r;
    wire float_sel = !strap_s2_r[rss_pkg::STRAP_UPPER_SEL] &&
                     !strap_s2_r[rss_pkg::STRAP_LOWER_SEL];
    wire queue_sel = !strap_s2_r[rss_pkg::STRAP_READ_QUEUE];
    wire wait_pin = strap_s2_r[rss_pkg::STRAP_COPROC_WAIT];
    wire lock_low = !strap_s2_r[rss_pkg::STRAP_LOCK];
    wire cnt_done = cnt_r == 8'(COPROC_DELAY - 1);
    wire inact_done = cnt_r == 8'(INACTIVE_CLKS - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rss_pkg::ST_RESET: begin
                if (!in_reset) state_nxt = wait_pin ? rss_pkg::ST_COPROC_WAIT : rss_pkg::ST_RUN;
            end
            rss_pkg::ST_INACTIVE: begin
                if (inact_done) state_nxt = rss_pkg::ST_RESET;
            end
            rss_pkg::ST_COPROC_WAIT: begin
                if (in_reset) state_nxt = rss_pkg::ST_INACTIVE;
                else if (cnt_done) state_nxt = rss_pkg::ST_RUN;
            end
            rss_pkg::ST_RUN: begin
                if (in_reset) state_nxt = rss_pkg::ST_INACTIVE;
            end
            default: state_nxt = rss_pkg::ST_RESET;
        endcase
    end

    wire leaving_reset = state_r == rss_pkg::ST_RESET && !in_reset;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= rss_pkg::ST_RESET;
            cnt_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r <= (state_nxt != state_r) ? 8'h00 : cnt_r + 8'h01;
        end
    end

    // Mode flags latched at release, coprocessor confirmed after the delay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            float_r <= 1'b0;
            queue_r <= 1'b0;
            coproc_r <= 1'b0;
            lockerr_r <= 1'b0;
        end else begin
            if (leaving_reset) begin
                float_r <= float_sel;
                queue_r <= queue_sel;
                coproc_r <= 1'b0;
            end
            if (state_r == rss_pkg::ST_COPROC_WAIT && cnt_done && !in_reset)
                coproc_r <= !wait_pin;
            // Diagnostic only; a low lock strap is board misuse
            if (state_r == rss_pkg::ST_RESET && lock_low)
                lockerr_r <= 1'b1;
        end
    end

    // Pins: drive inactive first, then float with pull-ups during reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_oe_n_r <= 1'b1;
            pin_oe_n_r <= {rss_pkg::STRAP_W{1'b1}};
            pin_pu_r <= {rss_pkg::STRAP_W{1'b1}};
            core_rst_n_r <= 1'b0;
        end else begin
            core_rst_n_r <= state_nxt == rss_pkg::ST_RUN;
            ctrl_oe_n_r <= state_nxt == rss_pkg::ST_RESET;
            pin_oe_n_r <= (state_nxt == rss_pkg::ST_RESET) ?
                          {rss_pkg::STRAP_W{1'b1}} : {rss_pkg::STRAP_W{1'b0}};
            pin_pu_r <= (state_nxt == rss_pkg::ST_RESET) ?
                        {rss_pkg::STRAP_W{1'b1}} : {rss_pkg::STRAP_W{1'b0}};
        end
    end

    // AHB-Lite slave, zero wait states
    wire ap_take = hsel && hready && (htrans == rss_pkg::HTRANS_NONSEQ ||
                                      htrans == rss_pkg::HTRANS_SEQ);
    wire wr_ctrl = dp_valid_r && dp_write_r && dp_addr_r == rss_pkg::ADDR_CTRL;
    wire [31:0] mode_word = {29'h0, coproc_r, queue_r, float_r};
    wire [31:0] stat_word = {29'h0, lockerr_r, float_r, in_reset};
    wire [31:0] ctrl_word = {31'h0, hold_r};
    wire [31:0] rd_word = (haddr == rss_pkg::ADDR_MODE) ? mode_word :
                          (haddr == rss_pkg::ADDR_STATUS) ? stat_word :
                          (haddr == rss_pkg::ADDR_CTRL) ? ctrl_word : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r <= 12'h000;
            hrdata_r <= 32'h0;
            hold_r <= 1'b0;
        end else begin
            dp_valid_r <= ap_take;
            dp_write_r <= hwrite;
            dp_addr_r <= haddr;
            if (ap_take && !hwrite) hrdata_r <= rd_word;
            // Software reset hold acts like the reset pin
            if (wr_ctrl) hold_r <= hwdata[rss_pkg::CTRL_HOLD_BIT];
        end
    end

    assign strap_out = {rss_pkg::STRAP_W{1'b1}};
    assign strap_oe_n = pin_oe_n_r;
    assign strap_pullup = pin_pu_r;
    assign bus_ctrl_oe_n = ctrl_oe_n_r;
    assign core_reset_n = core_rst_n_r;
    assign emulation_float_mode = float_r;
    assign queue_report_strap = queue_r;
    assign coproc_mode = coproc_r;
    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule // rss_top
`default_nettype wire

// [tb/rss_board.sv]
`timescale 1ns/100ps
`default_nettype none
module rss_board (
    // Device strap pins
    input wire logic [6:0] strap_out,
    input wire logic [6:0] strap_oe_n,
    // Board strap resistors, 1 = tied low
    input wire logic [6:0] pull_low,
    // Resolved pin levels
    output logic [6:0] strap_in
);
    // Board resistors beat the weak pull-ups; the lock pin is never tied low
    assign strap_in = ~(pull_low & 7'h5F) & (strap_oe_n | strap_out);
endmodule // rss_board
`default_nettype wire

// [tb/rss_top_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module rss_top_assertions (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Board side
    input wire logic reset_in_n,
    input wire logic [6:0] strap_in,
    // Device outputs
    input wire logic [6:0] strap_oe_n,
    input wire logic [6:0] strap_pullup,
    input wire logic bus_ctrl_oe_n,
    input wire logic core_reset_n,
    input wire logic emulation_float_mode,
    input wire logic queue_report_strap,
    input wire logic coproc_mode
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic [6:0] strap_r;
    // Last levels seen while the pins were inputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            strap_r <= 7'h7F;
        else if (strap_pullup[0])
            strap_r <= strap_in;
    end
    sequence s_held;
        (!reset_in_n) [*6];
    endsequence
    sequence s_left;
        $rose(core_reset_n) ##1 1'h1;
    endsequence
    sequence s_left_nowait;
        ($rose(core_reset_n) && !strap_r[6]) ##1 1'h1;
    endsequence
    chk_core_held: assert property (s_held |-> !core_reset_n)
        else $error("core left running in reset");
    chk_pins_input: assert property (s_held |-> &strap_oe_n && &strap_pullup && bus_ctrl_oe_n)
        else $error("strap pins not pulled-up inputs");
    chk_sync_lag: assert property ($fell(reset_in_n) && core_reset_n |=> core_reset_n)
        else $error("reset taken without sync");
    chk_drive_first: assert property ($rose(bus_ctrl_oe_n) && !reset_in_n |-> !$past(reset_in_n, 3))
        else $error("controls floated too early");
    chk_sync_release: assert property ($rose(core_reset_n) |-> $past(reset_in_n, 2) && $past(reset_in_n))
        else $error("release not synchronised");
    chk_float_latch: assert property (s_left |-> emulation_float_mode == (!strap_r[1] && !strap_r[2]))
        else $error("float flag wrong");
    chk_queue_latch: assert property (s_left |-> queue_report_strap == !strap_r[0])
        else $error("queue flag wrong");
    chk_coproc_cause: assert property ($rose(coproc_mode) |-> strap_r[6] && !strap_in[6])
        else $error("coproc mode without its sequence");
    chk_coproc_off: assert property (s_left_nowait |-> (!coproc_mode) [*8])
        else $error("coproc mode with wait low in reset");
endmodule // rss_top_assertions
bind rss_top rss_top_assertions chk (.hclk, .hresetn, .reset_in_n, .strap_in, .strap_oe_n,
    .strap_pullup, .bus_ctrl_oe_n, .core_reset_n, .emulation_float_mode,
    .queue_report_strap, .coproc_mode);
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic reset_in_n = 1'h0;
    logic [6:0] pull_low = 7'h00;
    logic [6:0] strap_in, strap_out, strap_oe_n, strap_pullup;
    logic bus_ctrl_oe_n, core_reset_n, emulation_float_mode, queue_report_strap;
    logic coproc_mode, hreadyout, hresp;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, d;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    // Bit 7 ties the wait pin low a few clocks after release
    logic [7:0] tbl [5] = '{8'h86, 8'h01, 8'h82, 8'hC0, 8'h00};
    always #20 hclk = ~hclk;
    rss_top dut (.hclk, .hresetn, .reset_in_n, .strap_in, .strap_out, .strap_oe_n,
        .strap_pullup, .bus_ctrl_oe_n, .core_reset_n, .emulation_float_mode,
        .queue_report_strap, .coproc_mode, .hsel, .haddr, .htrans, .hwrite,
        .hsize({1'h0, rss_pkg::HSIZE_WORD}), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp);
    rss_board board (.strap_out, .strap_oe_n, .pull_low, .strap_in);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= rss_pkg::HTRANS_NONSEQ;
        @(posedge hclk);
        while (hreadyout !== 1'h1)
            @(posedge hclk);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'h1)
            @(posedge hclk);
        d = hrdata;
    endtask
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        // Board reset stays low from power-up until the clock is steady
        repeat (4) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
        reset_in_n <= 1'h1;
        repeat (12) @(posedge hclk);
        bus(1'h1, rss_pkg::ADDR_CTRL, 32'h1);
        bus(1'h0, rss_pkg::ADDR_CTRL, 32'h0);
        check(d, 32'h1);
        bus(1'h1, rss_pkg::ADDR_CTRL, 32'h0);
        bus(1'h0, 12'h010, 32'h0);
        check(d, 32'h0);
        repeat (8) @(posedge hclk);
        foreach (tbl[i]) begin
            reset_in_n <= 1'h0;
            pull_low <= {tbl[i][6], 3'h0, tbl[i][2:0]};
            @(posedge hclk);
            @(negedge hclk);
            check(core_reset_n, 1'h1);
            repeat (8) @(negedge hclk);
            check({core_reset_n, bus_ctrl_oe_n}, 2'h1);
            check(strap_oe_n & strap_pullup, 7'h7F);
            @(posedge hclk);
            bus(1'h0, rss_pkg::ADDR_STATUS, 32'h0);
            check(d[rss_pkg::STAT_RESET_BIT], 1'h1);
            // Float and queue straps stay tied well past release
            reset_in_n <= 1'h1;
            repeat (4) @(posedge hclk);
            pull_low[6] <= tbl[i][7];
            repeat (12) @(posedge hclk);
            bus(1'h0, rss_pkg::ADDR_MODE, 32'h0);
            check(d, {tbl[i][7] & ~tbl[i][6], tbl[i][0], tbl[i][1] & tbl[i][2]});
            check({coproc_mode, queue_report_strap, emulation_float_mode}, d[2:0]);
            check({core_reset_n, bus_ctrl_oe_n, strap_pullup}, 9'h100);
        end
        end_sim();
    end
endmodule // testbench
`default_nettype wire
